// ===== fkl_flash_key_lock.sv
// top of the flash key lock and timing block
// assumes firmware reaches the registers over an 8-bit register port
//
// Operation
// (R1) key A5 then F1 grants one operation
// (R2) permission withdrawn after one operation completes
// (R3) wrong or out-of-order key locks until reset
// (R4) unpermitted write or erase locks until reset
// (R5) firmware may lock deliberately with non-first key
// (R6) key register reads lock state in bits 1:0
// (R7) read-time bit low gives one-cycle strobe
// (R8) read-time bit high gives two-cycle strobe
// (R9) firmware picks smallest allowed read time
// (R10) erase/write bit selects short or extended timing
// (R11) firmware sets extended timing before operations
// (R12) reset returns lock state to locked
// (R13) firmware writes zero to reserved timing bits
module fkl_flash_key_lock (
   input  wire logic       clk_sys_i,        // core clock
   input  wire logic       sys_rst_i,        // synchronous reset
   input  wire logic [7:0] reg_addr_i,       // register address
   input  wire logic       reg_wr_i,         // register write strobe
   input  wire logic       reg_rd_i,         // register read strobe
   input  wire logic [7:0] reg_wdata_i,      // register write data
   input  wire logic       flash_op_req_i,   // write or erase attempt pulse
   input  wire logic       flash_op_done_i,  // operation complete pulse
   input  wire logic       flash_rd_req_i,   // flash read request pulse
   output logic      [7:0] reg_rdata_o,      // register read data
   output logic            flash_op_go_o,    // operation accepted pulse
   output logic            flash_op_block_o, // attempt refused pulse
   output logic            ew_permit_o,      // permission held
   output logic            ew_extended_o,    // extended erase/write timing
   output logic            flash_rd_strobe_o // flash read strobe
);
   typedef enum logic [2:0] {LK_LOCKED, LK_FIRST, LK_OPEN, LK_BUSY, LK_DEAD} fkl_lock_e;
   fkl_lock_e  lock;
   logic [7:0] timing;
   logic [1:0] lock_code;
   logic       key_wr;
   logic       tim_wr;
   fkl_strobe_if sif ();

   assign key_wr = reg_wr_i && reg_addr_i == fkl_pkg::KEY_ADDR;
   assign tim_wr = reg_wr_i && reg_addr_i == fkl_pkg::TIMING_ADDR;

   // lock state machine
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         lock <= LK_LOCKED; // [R12]
      end else begin
         case (lock)
            LK_LOCKED: begin
               if (flash_op_req_i) lock <= LK_DEAD; // [R4]
               else if (key_wr && reg_wdata_i == fkl_pkg::KEY_FIRST) lock <= LK_FIRST; // [R1]
               else if (key_wr) lock <= LK_DEAD; // [R3] [R5]
            end
            LK_FIRST: begin
               if (flash_op_req_i) lock <= LK_DEAD; // [R4]
               else if (key_wr && reg_wdata_i == fkl_pkg::KEY_SECOND) lock <= LK_OPEN; // [R1]
               else if (key_wr) lock <= LK_DEAD; // [R3]
            end
            LK_OPEN: begin
               if (key_wr) lock <= LK_DEAD; // [R3]
               else if (flash_op_req_i) lock <= LK_BUSY; // [R1]
            end
            LK_BUSY: begin
               if (key_wr) lock <= LK_DEAD; // [R3]
               else if (flash_op_req_i) lock <= LK_DEAD; // [R4]
               else if (flash_op_done_i) lock <= LK_LOCKED; // [R2]
            end
            LK_DEAD: lock <= LK_DEAD;
            default: lock <= LK_DEAD;
         endcase
      end
   end

   // encoded lock state, busy still reads unlocked
   always_comb begin
      case (lock)
         LK_LOCKED: lock_code = fkl_pkg::LOCK_LOCKED;
         LK_FIRST:  lock_code = fkl_pkg::LOCK_FIRST;
         LK_OPEN:   lock_code = fkl_pkg::LOCK_OPEN;
         LK_BUSY:   lock_code = fkl_pkg::LOCK_OPEN;
         default:   lock_code = fkl_pkg::LOCK_DEAD;
      endcase
   end

   // operation accept and refuse pulses
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         flash_op_go_o    <= 1'b0;
         flash_op_block_o <= 1'b0;
         ew_permit_o      <= 1'b0;
      end else begin
         flash_op_go_o    <= flash_op_req_i && lock == LK_OPEN && !key_wr; // [R1]
         flash_op_block_o <= flash_op_req_i && !(lock == LK_OPEN && !key_wr); // [R4]
         ew_permit_o      <= lock == LK_OPEN; // [R2]
      end
   end

   // timing register, reserved bits held at zero
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) timing <= fkl_pkg::TIMING_RESET;
      else if (tim_wr) timing <= reg_wdata_i & fkl_pkg::TIMING_WR_MASK;
   end

   // extended timing output
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) ew_extended_o <= 1'b0;
      else ew_extended_o <= timing[fkl_pkg::EW_TIME_BIT]; // [R10]
   end

   // register read data
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         if (reg_addr_i == fkl_pkg::KEY_ADDR) reg_rdata_o <= {6'h00, lock_code}; // [R6]
         else if (reg_addr_i == fkl_pkg::TIMING_ADDR) reg_rdata_o <= timing;
         else reg_rdata_o <= 8'h00;
      end
   end

   // strobe length from read-time bit
   assign sif.req = flash_rd_req_i;
   assign sif.len = timing[fkl_pkg::READ_TIME_BIT] ? fkl_pkg::STROBE_LONG // [R8]
                                                   : fkl_pkg::STROBE_SHORT; // [R7]

   fkl_read_strobe u_strobe (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .sif       (sif),
      .strobe_o  (flash_rd_strobe_o)
   );

   a_dead_holds: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
      lock == LK_DEAD |=> lock == LK_DEAD)
      else $error("permanent lock released");
   a_bad_key_locks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
      key_wr && lock == LK_FIRST && reg_wdata_i != fkl_pkg::KEY_SECOND |=> lock == LK_DEAD)
      else $error("wrong second key not locked");
   a_key_seq_open: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R1]
      key_wr && reg_wdata_i == fkl_pkg::KEY_FIRST && lock == LK_LOCKED && !flash_op_req_i
      ##1 key_wr && reg_wdata_i == fkl_pkg::KEY_SECOND && !flash_op_req_i |=> lock == LK_OPEN)
      else $error("key sequence did not unlock");
   a_done_relock: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R2]
      lock == LK_BUSY && flash_op_done_i && !key_wr |=> lock == LK_LOCKED ##1 !ew_permit_o)
      else $error("permission not withdrawn");
   a_unpermit_op: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
      flash_op_req_i && lock == LK_LOCKED |=> flash_op_block_o && !flash_op_go_o && lock == LK_DEAD)
      else $error("unpermitted operation not blocked");
   a_state_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
      reg_rd_i && reg_addr_i == fkl_pkg::KEY_ADDR && lock == LK_DEAD |=> reg_rdata_o == 8'h03)
      else $error("lock state read wrong");
   a_strobe_short: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R7]
      flash_rd_req_i && !flash_rd_strobe_o && !timing[fkl_pkg::READ_TIME_BIT]
      ##1 !flash_rd_req_i |=> !flash_rd_strobe_o)
      else $error("short strobe too long");
   a_strobe_long: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R8]
      flash_rd_req_i && !flash_rd_strobe_o && timing[fkl_pkg::READ_TIME_BIT]
      |=> flash_rd_strobe_o [*2])
      else $error("long strobe not two cycles");
   a_ew_timing: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R10]
      tim_wr |=> ##1 ew_extended_o == $past(reg_wdata_i[1], 2))
      else $error("erase/write timing not applied");

   // accepted attempt starts the one permitted operation
   a_op_go_open: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R1]
      flash_op_req_i && lock == LK_OPEN && !key_wr |=> flash_op_go_o && lock == LK_BUSY)
      else $error("permitted operation not accepted");
   // accept pulse only out of the unlocked state
   a_go_only_open: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R1]
      flash_op_go_o |-> $past(lock == LK_OPEN))
      else $error("operation accepted while not unlocked");
   // second attempt during an operation is refused
   a_busy_req_dead: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
      flash_op_req_i && lock == LK_BUSY |=> flash_op_block_o && lock == LK_DEAD)
      else $error("attempt during operation not refused");
   // refuse pulse only follows an attempt
   a_block_has_req: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
      flash_op_block_o |-> $past(flash_op_req_i))
      else $error("refuse pulse without attempt");
   // accept and refuse never together
   a_go_block_excl: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R4]
      !(flash_op_go_o && flash_op_block_o))
      else $error("accept and refuse at once");
   // wrong first key locks for good
   a_wrong_first: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
      key_wr && lock == LK_LOCKED && reg_wdata_i != fkl_pkg::KEY_FIRST |=> lock == LK_DEAD)
      else $error("wrong first key not locked");
   // any key write after unlocking locks for good
   a_open_key_dead: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R3]
      key_wr && (lock == LK_OPEN || lock == LK_BUSY) |=> lock == LK_DEAD)
      else $error("key write while unlocked not locked");
   // locked state reads 00
   a_locked_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
      reg_rd_i && reg_addr_i == fkl_pkg::KEY_ADDR && lock == LK_LOCKED |=> reg_rdata_o == 8'h00)
      else $error("locked state read wrong");
   // first key state reads 01
   a_first_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
      reg_rd_i && reg_addr_i == fkl_pkg::KEY_ADDR && lock == LK_FIRST |=> reg_rdata_o == 8'h01)
      else $error("first key state read wrong");
   // unlocked and busy states read 10
   a_open_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R6]
      reg_rd_i && reg_addr_i == fkl_pkg::KEY_ADDR && (lock == LK_OPEN || lock == LK_BUSY)
      |=> reg_rdata_o == 8'h02)
      else $error("unlocked state read wrong");
   // permission level tracks the unlocked state
   a_permit_level: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R2]
      1'b1 |=> ew_permit_o == $past(lock == LK_OPEN))
      else $error("permission level wrong");
   // reset returns to locked with no permission
   a_reset_locked: assert property (@(posedge clk_sys_i) // [R12]
      sys_rst_i |=> lock == LK_LOCKED && !ew_permit_o)
      else $error("reset did not lock");
   // extended timing output follows the stored bit
   a_ext_follows: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R10]
      1'b1 |=> ew_extended_o == $past(timing[fkl_pkg::EW_TIME_BIT]))
      else $error("extended timing output stale");
   // a strobe only starts after a read request
   a_strobe_has_req: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // [R7]
      $rose(flash_rd_strobe_o) |-> $past(flash_rd_req_i))
      else $error("strobe without request");
endmodule

// ===== fkl_pkg.sv
// package for the flash key lock and timing block
// assumes an 8-bit special function register bus on the core clock
package fkl_pkg;
   // register addresses
   localparam logic [7:0] TIMING_ADDR    = 8'hB6;
   localparam logic [7:0] KEY_ADDR       = 8'hB7;
   // key values
   localparam logic [7:0] KEY_FIRST      = 8'hA5;
   localparam logic [7:0] KEY_SECOND     = 8'hF1;
   // timing register fields and reset
   localparam int         READ_TIME_BIT  = 4;
   localparam int         EW_TIME_BIT    = 1;
   localparam logic [7:0] TIMING_RESET   = 8'h00;
   localparam logic [7:0] TIMING_WR_MASK = 8'h12;
   // lock state codes
   localparam logic [1:0] LOCK_LOCKED    = 2'h0;
   localparam logic [1:0] LOCK_FIRST     = 2'h1;
   localparam logic [1:0] LOCK_OPEN      = 2'h2;
   localparam logic [1:0] LOCK_DEAD      = 2'h3;
   // read strobe lengths in core clock cycles
   localparam logic [1:0] STROBE_SHORT   = 2'h1;
   localparam logic [1:0] STROBE_LONG    = 2'h2;
endpackage

// ===== fkl_strobe_if.sv
// carrier between the lock block and its read strobe shaper
// assumes one clock shared by both ends
interface fkl_strobe_if;
   logic       req;  // read request pulse
   logic [1:0] len;  // strobe length in cycles
   logic       busy; // strobe in progress
   modport ctl (output req, output len, input busy);
   modport shp (input req, input len, output busy);
endinterface

// ===== fkl_read_strobe.sv
// flash read strobe shaper, one or two cycles long
// assumes synchronous active-high reset on the core clock
module fkl_read_strobe (
   input  wire logic clk_sys_i,   // core clock
   input  wire logic sys_rst_i,   // synchronous reset
   fkl_strobe_if.shp sif,         // request side
   output logic      strobe_o     // flash read strobe
);
   logic [1:0] left;

   // count strobe cycles
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         left     <= 2'h0;
         strobe_o <= 1'b0;
      end else if (sif.req && left <= 2'h1) begin
         left     <= sif.len;
         strobe_o <= 1'b1;
      end else if (left > 2'h1) begin
         left     <= left - 2'h1;
         strobe_o <= 1'b1;
      end else begin
         left     <= 2'h0;
         strobe_o <= 1'b0;
      end
   end
   assign sif.busy = strobe_o;
endmodule

// ===== fkl_flash_key_lock_bench.sv
// self-checking bench for the flash key lock and timing block
// assumes fkl_pkg, the strobe interface and the design modules are compiled first
module fkl_flash_key_lock_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic       reg_rd_i = 1'b0;
   logic       flash_op_req_i = 1'b0;
   logic       flash_op_done_i = 1'b0;
   logic       flash_rd_req_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic       flash_op_go_o, flash_op_block_o, ew_permit_o, ew_extended_o, flash_rd_strobe_o;
   logic       rd_p1 = 1'b0;
   logic       rd_p2 = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] v;
   int         failures = 0;
   int         n_checks = 0;
   localparam logic [7:0] KA = fkl_pkg::KEY_ADDR;
   localparam logic [7:0] TA = fkl_pkg::TIMING_ADDR;

   // 40 MHz core clock
   always #12.5 clk_sys_i = ~clk_sys_i;

   fkl_flash_key_lock i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .flash_op_req_i(flash_op_req_i),
      .flash_op_done_i(flash_op_done_i), .flash_rd_req_i(flash_rd_req_i),
      .reg_rdata_o(reg_rdata_o), .flash_op_go_o(flash_op_go_o),
      .flash_op_block_o(flash_op_block_o), .ew_permit_o(ew_permit_o),
      .ew_extended_o(ew_extended_o), .flash_rd_strobe_o(flash_rd_strobe_o));

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // read data compared against the oldest note once it has settled
   always @(posedge clk_sys_i) begin
      rd_p1 <= reg_rd_i;
      rd_p2 <= rd_p1;
   end
   always @(negedge clk_sys_i) begin
      if (rd_p2 && exp_q.size() > 0) chk("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
      @(posedge clk_sys_i) reg_wr_i <= 1'b0;
   endtask

   // reads are spaced so the held read data is checked before the next one
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_sys_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
      @(posedge clk_sys_i) reg_rd_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
   endtask

   // one attempt, counting accept and refuse pulses that follow it
   task automatic op(input int eg, input int eb);
      int g = 0;
      int b = 0;
      @(posedge clk_sys_i) flash_op_req_i <= 1'b1;
      @(posedge clk_sys_i) flash_op_req_i <= 1'b0;
      repeat (4) begin
         @(negedge clk_sys_i);
         if (flash_op_go_o === 1'b1) g++;
         if (flash_op_block_o === 1'b1) b++;
      end
      chk("flash_op_go_o", 8'(eg), 8'(g));
      chk("flash_op_block_o", 8'(eb), 8'(b));
      if (eg == 1) begin
         @(posedge clk_sys_i) flash_op_done_i <= 1'b1;
         @(posedge clk_sys_i) flash_op_done_i <= 1'b0;
      end
   endtask

   task automatic strobe(input int len);
      int n = 0;
      @(posedge clk_sys_i) flash_rd_req_i <= 1'b1;
      @(posedge clk_sys_i) flash_rd_req_i <= 1'b0;
      repeat (5) begin
         @(negedge clk_sys_i);
         if (flash_rd_strobe_o === 1'b1) n++;
      end
      chk("flash_rd_strobe_o", 8'(len), 8'(n));
   endtask

   task automatic rst;
      @(posedge clk_sys_i) sys_rst_i <= 1'b1;
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
   endtask

   // main sequence
   initial begin
      void'($urandom(12944));
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rd(KA, 8'h00);
      rd(TA, fkl_pkg::TIMING_RESET);
      rd(8'h00, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = ((i < 2) ? (i == 1 ? 8'hFF : 8'h00) : 8'($urandom)) & 8'h12;
         wr(TA, v);
         rd(TA, v & 8'h12);
         chk("ew_extended_o", 8'(v[1]), 8'(ew_extended_o));
         strobe(v[4] ? 2 : 1);
      end
      wr(TA, 8'h12);
      wr(KA, fkl_pkg::KEY_FIRST);
      rd(KA, 8'h01);
      wr(KA, fkl_pkg::KEY_SECOND);
      rd(KA, 8'h02);
      chk("ew_permit_o", 8'h01, 8'(ew_permit_o));
      op(1, 0);
      chk("ew_permit_o", 8'h00, 8'(ew_permit_o));
      rd(KA, 8'h00);
      op(0, 1);
      rd(KA, 8'h03);
      op(0, 1);
      rst;
      wr(KA, fkl_pkg::KEY_FIRST);
      wr(KA, 8'h00);
      rd(KA, 8'h03);
      rst;
      rd(KA, 8'h00);
      wr(KA, fkl_pkg::KEY_SECOND);
      rd(KA, 8'h03);
      op(0, 1);
      rst;
      wr(TA, 8'h12);
      wr(KA, fkl_pkg::KEY_FIRST);
      wr(KA, fkl_pkg::KEY_SECOND);
      @(posedge clk_sys_i) flash_op_req_i <= 1'b1;
      @(posedge clk_sys_i) flash_op_req_i <= 1'b0;
      op(0, 1);
      rd(KA, 8'h03);
      rst;
      rd(KA, 8'h00);
      conclude;
   end

   // watchdog well beyond the expected run length
   initial begin
      #(25 * 6000);
      failures++;
      conclude;
   end
endmodule
